// ---- core/sram_base_decode_consts.vh ----
// constants for the local sram base configuration register and decode
`ifndef SRAM_BASE_DECODE_CONSTS_VH
`define SRAM_BASE_DECODE_CONSTS_VH
`define SBD_BASE_HI        31
`define SBD_BASE_LO        15
`define SBD_WP_BIT         8
`define SBD_MASK_HI        5
`define SBD_MASK_LO        1
`define SBD_VALID_BIT      0
`define SBD_DEFINED_BITS   32'hffff_813f
`define SBD_MASK_CPU       3'd4
`define SBD_MASK_SC        3'd3
`define SBD_MASK_SD        3'd2
`define SBD_MASK_UC        3'd1
`define SBD_MASK_UD        3'd0
`define SBD_SPACE_CPU      3'd0
`define SBD_SPACE_SC       3'd1
`define SBD_SPACE_SD       3'd2
`define SBD_SPACE_UC       3'd3
`define SBD_SPACE_UD       3'd4
`define SBD_WORD_LO        2
`define SBD_WORD_HI        11
`define SBD_WIN_HI         14
`define SBD_WIN_LO         12
`endif

// ---- core/sram_array.v ----
// 1024 x 32 local sram array with per-byte write enables
`timescale 1ns/10ps
module sram_array #(
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  input  wire          clk,
  input  wire          wr_en,
  input  wire [3:0]    byte_en,
  input  wire [AW-1:0] addr,
  input  wire [31:0]   wdata,
  output reg  [31:0]   rdata
);
  reg [31:0] mem [0:DEPTH-1];
  integer    i;

  // byte lanes allow byte, word and longword stores
  always @(posedge clk) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (wr_en && byte_en[i]) begin
        mem[addr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
    rdata <= mem[addr];
  end
endmodule // sram_array

// ---- core/sram_base_decode.v ----
// local sram base configuration register, hit/protect decode and array
`timescale 1ns/10ps
`include "sram_base_decode_consts.vh"
module sram_base_decode #(
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // register writes from the processor and the debug port, and the debug read request
  input  wire        cpu_cfg_wr,
  input  wire [31:0] cpu_cfg_wdata,
  input  wire        dbg_cfg_wr,
  input  wire        dbg_cfg_rd,
  input  wire [31:0] dbg_cfg_wdata,
  // debug read answer
  output reg  [31:0] dbg_cfg_rdata,
  output reg         dbg_cfg_rvalid,
  // local bus reference
  input  wire        ref_valid,
  input  wire [31:0] ref_addr,
  input  wire        ref_write,
  input  wire [2:0]  ref_space,
  input  wire [3:0]  ref_byte_en,
  input  wire [31:0] ref_wdata,
  // reference results, one cycle after the reference, and the enable status
  output reg         ref_hit,
  output reg         ref_forward,
  output reg         ref_access_error,
  output reg         ref_cache_discard,
  output reg         ref_no_allocate,
  output reg         ref_rvalid,
  output wire [31:0] ref_rdata,
  output reg         sram_enabled
);
  // register state and its next value
  reg  [31:0] cfg_q;
  reg  [31:0] cfg_d;
  reg         valid_q;
  reg         valid_d;
  reg         wr_take;
  reg  [31:0] wr_word;

  // decode terms
  wire [31:0] cfg_view;
  wire        base_match;
  wire        low_zero;
  wire        in_window;
  wire        space_ok;
  wire        hit;
  wire        rd_hit;
  wire        wr_hit;
  wire        do_write;
  wire [3:0]  lane_we;

  // next values of the registered outputs
  reg         ref_hit_d;
  reg         ref_forward_d;
  reg         ref_access_error_d;
  reg         ref_cache_discard_d;
  reg         ref_no_allocate_d;
  reg         ref_rvalid_d;
  reg  [31:0] dbg_cfg_rdata_d;

  // returns the mask bit that gates a given reference space
  function space_masked;
    input [4:0] masks;
    input [2:0] space;
    begin
      case (space)
        `SBD_SPACE_CPU: space_masked = masks[`SBD_MASK_CPU];
        `SBD_SPACE_SC:  space_masked = masks[`SBD_MASK_SC];
        `SBD_SPACE_SD:  space_masked = masks[`SBD_MASK_SD];
        `SBD_SPACE_UC:  space_masked = masks[`SBD_MASK_UC];
        `SBD_SPACE_UD:  space_masked = masks[`SBD_MASK_UD];
        default:        space_masked = 1'b1; // unknown spaces never reach sram
      endcase
    end
  endfunction

  // clears every reserved position; shared by the store and the debug view
  function [31:0] keep_defined;
    input [31:0] word;
    begin
      keep_defined = word & `SBD_DEFINED_BITS;
    end
  endfunction

  // combined view; reserved bits are forced to zero
  assign cfg_view = keep_defined({cfg_q[31:1], valid_q});

  // pick the writer; debug wins so an attached debugger is never locked out
  always @* begin
    wr_take = 1'b0;
    wr_word = 32'h0000_0000;
    if (dbg_cfg_wr) begin
      wr_take = 1'b1;
      wr_word = dbg_cfg_wdata;
    end else if (cpu_cfg_wr) begin
      wr_take = 1'b1;
      wr_word = cpu_cfg_wdata;
    end
  end

  // next state; reset forces only the valid bit low
  always @* begin
    cfg_d   = cfg_q;
    valid_d = valid_q;
    if (wr_take) begin
      cfg_d   = keep_defined(wr_word);
      valid_d = wr_word[`SBD_VALID_BIT];
    end
    if (!reset_n) begin
      valid_d = 1'b0;
    end
  end

  // field register is not reset: contents survive a reset by design
  always @(posedge clk) begin
    cfg_q <= reset_n ? cfg_d : cfg_q;
  end

  // valid bit alone takes reset
  always @(posedge clk) begin
    valid_q <= valid_d;
  end

  // base compare on bits 31..15 gives 32-Kbyte placement
  assign base_match = (ref_addr[`SBD_BASE_HI:`SBD_BASE_LO] == cfg_q[`SBD_BASE_HI:`SBD_BASE_LO]);
  // only the lowest 4 Kbytes of the 32-Kbyte region at the base are backed by the array
  assign low_zero   = (ref_addr[`SBD_WIN_HI:`SBD_WIN_LO] == 3'h0);
  // a reference hits only when enabled, in the window and not masked off
  assign in_window  = base_match && low_zero;
  assign space_ok   = !space_masked(cfg_q[`SBD_MASK_HI:`SBD_MASK_LO], ref_space);
  assign hit        = ref_valid && valid_q && in_window && space_ok;
  assign rd_hit     = hit && !ref_write;
  assign wr_hit     = hit && ref_write;
  assign do_write   = wr_hit && !cfg_q[`SBD_WP_BIT];
  // a protected or missed write leaves every byte lane closed
  assign lane_we    = do_write ? ref_byte_en : 4'h0;

  // next values of the reference flags, all from the one hit term
  always @* begin
    ref_hit_d           = hit;
    ref_forward_d       = ref_valid && !hit;
    ref_access_error_d  = wr_hit && cfg_q[`SBD_WP_BIT];
    ref_cache_discard_d = rd_hit;
    ref_no_allocate_d   = hit;
    ref_rvalid_d        = rd_hit;
    dbg_cfg_rdata_d     = 32'h0000_0000;
    if (dbg_cfg_rd) begin
      dbg_cfg_rdata_d = cfg_view;
    end
  end

  // reference flags registered to line up with the array read data
  always @(posedge clk) begin
    if (!reset_n) begin
      ref_hit           <= 1'b0;
      ref_forward       <= 1'b0;
      ref_access_error  <= 1'b0;
      ref_cache_discard <= 1'b0;
      ref_no_allocate   <= 1'b0;
      ref_rvalid        <= 1'b0;
    end else begin
      ref_hit           <= ref_hit_d;
      ref_forward       <= ref_forward_d;
      ref_access_error  <= ref_access_error_d;
      ref_cache_discard <= ref_cache_discard_d;
      ref_no_allocate   <= ref_no_allocate_d;
      ref_rvalid        <= ref_rvalid_d;
    end
  end

  // debug read port; zero outside the answer cycle so old views never linger
  always @(posedge clk) begin
    if (!reset_n) begin
      dbg_cfg_rdata  <= 32'h0000_0000;
      dbg_cfg_rvalid <= 1'b0;
    end else begin
      dbg_cfg_rdata  <= dbg_cfg_rdata_d;
      dbg_cfg_rvalid <= dbg_cfg_rd;
    end
  end

  // status tracks valid_q exactly, so it never lags the decode by a cycle
  always @(posedge clk) begin
    sram_enabled <= valid_d;
  end

  // storage array; a protected write never reaches it
  sram_array #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_array (
    .clk     (clk),
    .wr_en   (do_write),
    .byte_en (lane_we),
    .addr    (ref_addr[`SBD_WORD_LO +: AW]),
    .wdata   (ref_wdata),
    .rdata   (ref_rdata)
  );
endmodule // sram_base_decode

// ---- tb/sram_base_decode_monitor.sv ----
// port assertions for the sram decode
`timescale 1ns/10ps
module sram_base_decode_monitor (
  input logic clk, reset_n, dbg_cfg_rd, dbg_cfg_rvalid, ref_valid, ref_write,
  input logic ref_hit, ref_forward, ref_access_error, ref_cache_discard,
  input logic ref_no_allocate, ref_rvalid, sram_enabled,
  input logic [31:0] dbg_cfg_rdata, ref_addr,
  input logic [2:0] ref_space
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rd; dbg_cfg_rd |=> dbg_cfg_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_rz; dbg_cfg_rvalid |-> !(dbg_cfg_rdata & 32'h00007ec0); endproperty
  a_rz: assert property (p_rz) else $error("reserved bits read");
  // reset itself is the cause here, so no disable
  property p_rs; disable iff (1'b0) !reset_n |=> !sram_enabled; endproperty
  a_rs: assert property (p_rs) else $error("valid kept");
  property p_id; !ref_valid |=> !ref_hit && !ref_forward && !ref_access_error; endproperty
  a_id: assert property (p_id) else $error("flag without ref");
  property p_ds; ref_valid && !sram_enabled |=> ref_forward && !ref_hit; endproperty
  a_ds: assert property (p_ds) else $error("hit while off");
  property p_er; ref_access_error |-> $past(ref_write) && !ref_rvalid; endproperty
  a_er: assert property (p_er) else $error("error on read");
  property p_rh; ref_valid && !ref_write ##1 ref_hit |-> ref_rvalid && ref_cache_discard && ref_no_allocate;
  endproperty
  a_rh: assert property (p_rh) else $error("read hit flags");
  property p_wn; ref_valid && (ref_addr[14:12] != 0 || ref_space > 3'h4) |=> ref_forward; endproperty
  a_wn: assert property (p_wn) else $error("hit outside");
  c_ht: cover property (ref_hit);
  c_er: cover property (ref_access_error);
  c_rd: cover property (dbg_cfg_rvalid);
endmodule // sram_base_decode_monitor
bind sram_base_decode sram_base_decode_monitor i_sram_base_decode_monitor (.*);

// ---- tb/local_bus_model.sv ----
// processor and debug master feeding the sram decode
`timescale 1ns/10ps
module local_bus_model (
  input logic clk,
  output logic cpu_cfg_wr = 1'h0, dbg_cfg_wr = 1'h0, dbg_cfg_rd = 1'h0, ref_valid = 1'h0, ref_write = 1'h0,
  output logic [31:0] cpu_cfg_wdata = 32'h0, dbg_cfg_wdata = 32'h0, ref_addr = 32'h0, ref_wdata = 32'h0,
  output logic [2:0] ref_space = 3'h0,
  output logic [3:0] ref_byte_en = 4'hf
);
  // one request for one edge; released data is inverted so stale values never match
  // caller keeps reserved zeros, except the first t_cfg write, and the cpu mask for base zero
  task go(input logic [4:0] k, input logic [31:0] a, v, input logic [2:0] s);
    @(posedge clk);
    {cpu_cfg_wr, dbg_cfg_wr, dbg_cfg_rd, ref_valid, ref_write} <= k;
    {cpu_cfg_wdata, dbg_cfg_wdata, ref_wdata, ref_addr, ref_space} <= {{3{v}}, a, s};
    @(posedge clk);
    {cpu_cfg_wr, dbg_cfg_wr, dbg_cfg_rd, ref_valid, ref_write} <= 5'h0;
    {cpu_cfg_wdata, dbg_cfg_wdata, ref_wdata, ref_addr} <= {4{~v}};
    #1;
  endtask
  // byte lanes stay put across requests until changed here
  task lanes(input logic [3:0] b);
    @(posedge clk);
    ref_byte_en <= b;
  endtask
endmodule // local_bus_model

// ---- tb/sram_base_decode_tb.sv ----
// self-checking bench for the sram decode
`timescale 1ns/10ps
module sram_base_decode_tb;
  logic clk = 1'h0, reset_n = 1'h0;
  logic cpu_cfg_wr, dbg_cfg_wr, dbg_cfg_rd, ref_valid, ref_write, dbg_cfg_rvalid, sram_enabled;
  logic ref_hit, ref_forward, ref_access_error, ref_cache_discard, ref_no_allocate, ref_rvalid;
  logic [31:0] cpu_cfg_wdata, dbg_cfg_wdata, ref_addr, ref_wdata, dbg_cfg_rdata, ref_rdata;
  logic [2:0] ref_space;
  logic [3:0] ref_byte_en;
  int errors = 0, n_checks = 0;
  localparam logic [31:0] base = 32'h2000_8000; // odd 32k multiple
  local_bus_model i_local_bus_model (.*);
  sram_base_decode i_sram_base_decode (.*);
  initial forever #2 clk = ~clk;
  task chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // flags: hit, forward, error, rvalid
  task r(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] v, input logic [3:0] f);
    i_local_bus_model.go({4'h1, w}, a, v, s);
    chk({28'h0, ref_hit, ref_forward, ref_access_error, ref_rvalid}, {28'h0, f});
    chk({30'h0, ref_cache_discard, ref_no_allocate}, {30'h0, f[0], f[3]});
  endtask
  task t_cfg;
    i_local_bus_model.go(5'h08, 0, base | 32'h7ec1, 0);
    i_local_bus_model.go(5'h04, 0, 0, 0);
    chk(dbg_cfg_rdata, base | 32'h1);
    chk({31'h0, dbg_cfg_rvalid}, 1);
    chk({31'h0, sram_enabled}, 1);
    i_local_bus_model.go(5'h10, 0, base | 32'h3f, 0);
    i_local_bus_model.go(5'h04, 0, 0, 0);
    chk(dbg_cfg_rdata, base | 32'h3f);
  endtask
  task t_ref;
    i_local_bus_model.go(5'h08, 0, base | 32'h1, 0);
    r(base + 4, 1, 3'h2, 32'hcafe_f00d, 4'h8);
    r(base + 4, 0, 3'h4, 0, 4'h9);
    chk(ref_rdata, 32'hcafe_f00d);
    r(base + 8, 1, 3'h2, 32'h5555_aaaa, 4'h8);
    i_local_bus_model.lanes(4'h2);
    r(base + 8, 1, 3'h2, 32'h0000_3c00, 4'h8);
    i_local_bus_model.lanes(4'hf);
    r(base + 8, 0, 3'h2, 0, 4'h9);
    chk(ref_rdata, 32'h5555_3caa);
    r(base + 32'hffc, 0, 3'h3, 0, 4'h9);
    r(base + 32'h1000, 0, 3'h3, 0, 4'h4);
    r(base ^ 32'h8000, 0, 3'h1, 0, 4'h4);
    r(base + 4, 0, 3'h5, 0, 4'h4);
  endtask
  task t_mask;
    for (int s = 0; s < 5; s++) begin
      i_local_bus_model.go(5'h08, 0, base | 32'h1 | (32'h1 << (5 - s)), 0);
      r(base + 4, 0, 3'(s), 0, 4'h4);
      r(base + 4, 0, 3'((s + 1) % 5), 0, 4'h9);
    end
  endtask
  // base zero with the cpu-space mask set, as software must program it
  task t_zero;
    i_local_bus_model.go(5'h08, 0, 32'h21, 0);
    r(32'h4, 0, 3'h0, 0, 4'h4);
    r(32'h4, 0, 3'h2, 0, 4'h9);
  endtask
  task t_wp;
    i_local_bus_model.go(5'h08, 0, base | 32'h101, 0);
    i_local_bus_model.go(5'h03, base + 4, 32'h1234_5678, 3'h2);
    chk({31'h0, ref_access_error}, 1);
    r(base + 4, 0, 3'h2, 0, 4'h9);
    chk(ref_rdata, 32'hcafe_f00d);
  endtask
  task t_rst;
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    i_local_bus_model.go(5'h04, 0, 0, 0);
    chk(dbg_cfg_rdata, base | 32'h100);
    chk({31'h0, sram_enabled}, 0);
    r(base + 4, 0, 3'h2, 0, 4'h4);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
    t_cfg;
    t_ref;
    t_mask;
    t_zero;
    t_wp;
    t_rst;
    give_verdict;
  end
  // about 37 requests of 8 ns each; far more means a hang
  initial begin
    #20000;
    errors++;
    give_verdict;
  end
endmodule // sram_base_decode_tb
